/* File: logic/data_space_mapper.sv */
// Data-space decoder with ROM window, banked RAM/EEPROM, static and LCD RAM.
`timescale 1ns/1ps
// Notes on behaviour
// - Addresses 40h-7Fh read a ROM window.
// - Window moves in 64-byte steps, 13-bit ROM.
// - ROM address is window bits over offset.
// - Window register at C9h, write only.
// - Window register not cleared at reset.
// - Window bit 7 unused, low seven used.
// - Addresses 00h-3Fh reach the selected bank.
// - Bank register at CBh, write only.
// - Bank bit 0 selects the EEPROM page.
// - Bank bit 3 selects the RAM page.
// - Bank register not cleared at reset.
// - Static RAM at 80h-BFh, never banked.
// - Unbanked LCD RAM at E0h-F7h.
// - Sixty-four EEPROM bytes in one page.
// - EEPROM control at DFh, bit 6 off.
// - EEPROM reads time like RAM reads.
// - Busy flag readable; EEPROM blocked while busy.
// - Byte mode and eight-byte row mode.
// - Writes ignored unless write enable set.
// - EEPROM control resets to zero.
module data_space_mapper
    import data_space_pkg::*;
#(
    parameter int PROG_WAIT = PROG_CYCLES
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    // Core data-space bus
    input  wire core_req_s            core_req,
    output logic      [7:0]           core_rdata,
    // Program ROM read port
    output logic      [ROM_AW-1:0]    rom_addr,
    input  wire logic [7:0]           rom_data,
    // Status
    output logic                      ee_busy
);
    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic [7:0]             win_q;
    logic [7:0]             bank_q;
    logic [7:0]             ctl_q;
    logic [7:0]             sram_q [64];
    logic [7:0]             bram_q [64];
    logic [7:0]             lcd_q  [LCD_DEPTH];
    logic [7:0]             ee_q   [EE_DEPTH];
    logic [7:0]             row_q  [ROW_BYTES];
    logic [ROW_BYTES-1:0]   row_used_q;
    logic [2:0]             row_addr_q;
    logic [5:0]             byte_addr_q;
    logic [7:0]             byte_data_q;
    logic [15:0]            cnt_q;
    ee_state_e              st_q;
    logic                   byte_mode_q;
    logic [15:0]            busy_run_q;

    logic [7:0] a;
    logic [5:0] off;
    logic       hit_bank, hit_sram, hit_lcd, hit_win;
    logic       ee_sel, ram_sel, ee_ok, ee_wr;
    logic       busy;
    logic [4:0] lcd_idx;

    assign a        = core_req.addr;
    assign off      = a[OFFSET_BITS-1:0];
    assign hit_bank = in_range(a, BANK_LO, BANK_HI);
    assign hit_win  = in_range(a, ROMWIN_LO, ROMWIN_HI);
    assign hit_sram = in_range(a, SRAM_LO, SRAM_HI);
    assign hit_lcd  = in_range(a, LCD_LO, LCD_HI);
    assign lcd_idx  = 5'(a - LCD_LO);
    assign ee_sel   = bank_q[BANK_EE_BIT];
    assign ram_sel  = bank_q[BANK_RAM_BIT];
    assign busy     = (st_q == EE_PROG);
    assign ee_busy  = busy;
    // EEPROM usable only when powered, selected and idle.
    assign ee_ok    = ee_sel && !ctl_q[CTL_OFF_BIT] && !busy;
    assign ee_wr    = core_req.wr && hit_bank && ee_ok && ctl_q[CTL_ENA_BIT];
    assign rom_addr = {win_q[WINDOW_BITS-1:0], off};

    // ------------------------------------------------------------------
    // Mapping registers (no reset: contents undefined until written)
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (core_req.wr && a == ROM_WINDOW_ADDR) begin
            win_q <= core_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (core_req.wr && a == BANK_SEL_ADDR) begin
            bank_q <= core_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // RAM arrays
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (core_req.wr && hit_sram) begin
            sram_q[off] <= core_req.wdata;
        end
        if (core_req.wr && hit_bank && ram_sel) begin
            bram_q[off] <= core_req.wdata;
        end
        if (core_req.wr && hit_lcd) begin
            lcd_q[lcd_idx] <= core_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // EEPROM control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q <= CTL_RESET;
        end else if (st_q == EE_PROG && cnt_q == 16'(PROG_WAIT - 1)) begin
            ctl_q[CTL_ROW_BIT]   <= 1'b0;
            ctl_q[CTL_START_BIT] <= 1'b0;
        end else if (core_req.wr && a == EE_CTRL_ADDR && !busy) begin
            ctl_q[CTL_ENA_BIT] <= core_req.wdata[CTL_ENA_BIT];
            ctl_q[CTL_ROW_BIT] <= core_req.wdata[CTL_ROW_BIT];
            ctl_q[CTL_OFF_BIT] <= core_req.wdata[CTL_OFF_BIT];
            // Start only sticks when row mode is already on and row mode and enable stay set.
            ctl_q[CTL_START_BIT] <= core_req.wdata[CTL_START_BIT] && ctl_q[CTL_ROW_BIT] &&
                                    core_req.wdata[CTL_ROW_BIT] &&
                                    core_req.wdata[CTL_ENA_BIT];
        end
    end

    // ------------------------------------------------------------------
    // EEPROM write engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q        <= EE_IDLE;
            cnt_q       <= 16'h0000;
            row_used_q  <= '0;
            row_addr_q  <= 3'h0;
            byte_addr_q <= 6'h00;
            byte_data_q <= 8'h00;
            byte_mode_q <= 1'b0;
        end else begin
            unique case (st_q)
                EE_IDLE: begin
                    cnt_q <= 16'h0000;
                    if (ctl_q[CTL_ROW_BIT]) begin
                        st_q       <= EE_ROW_LOAD;
                        row_used_q <= '0;
                    end else if (ee_wr) begin
                        st_q        <= EE_PROG;
                        byte_mode_q <= 1'b1;
                        byte_addr_q <= off;
                        byte_data_q <= core_req.wdata;
                    end
                end
                EE_ROW_LOAD: begin
                    if (ee_wr) begin
                        if (row_used_q == '0) begin
                            row_addr_q <= off[5:3];
                        end
                        row_used_q[off[2:0]] <= 1'b1;
                    end
                    if (!ctl_q[CTL_ROW_BIT]) begin
                        st_q <= EE_IDLE;
                    end else if (ctl_q[CTL_START_BIT]) begin
                        st_q        <= EE_PROG;
                        byte_mode_q <= 1'b0;
                    end
                end
                EE_PROG: begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (cnt_q == 16'(PROG_WAIT - 1)) begin
                        st_q <= EE_IDLE;
                    end
                end
                default: st_q <= EE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (st_q == EE_ROW_LOAD && ee_wr) begin
            row_q[off[2:0]] <= core_req.wdata;
        end
    end

    for (genvar i = 0; i < EE_DEPTH; i++) begin : g_ee
        always_ff @(posedge clk) begin
            if (st_q == EE_PROG && cnt_q == 16'(PROG_WAIT - 1)) begin
                if (byte_mode_q && byte_addr_q == 6'(i)) begin
                    ee_q[i] <= byte_data_q;
                end else if (!byte_mode_q && row_addr_q == 3'(i / ROW_BYTES) &&
                             row_used_q[i % ROW_BYTES]) begin
                    ee_q[i] <= row_q[i % ROW_BYTES];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data (registered: same one-cycle latency for every region)
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_rdata <= 8'h00;
        end else if (core_req.rd) begin
            if (hit_win) begin
                core_rdata <= rom_data;
            end else if (hit_sram) begin
                core_rdata <= sram_q[off];
            end else if (hit_lcd) begin
                core_rdata <= lcd_q[lcd_idx];
            end else if (hit_bank && ram_sel) begin
                core_rdata <= bram_q[off];
            end else if (hit_bank && ee_ok) begin
                core_rdata <= ee_q[off];
            end else if (a == EE_CTRL_ADDR) begin
                core_rdata <= {6'h00, busy, 1'b0};
            end else begin
                core_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Programming run length
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_run_q <= 16'h0000;
        end else if (busy) begin
            busy_run_q <= busy_run_q + 16'h0001;
        end else begin
            busy_run_q <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_ctl_reset;
        @(posedge clk) $fell(sys_rst) |-> $past(ctl_q) == CTL_RESET;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset) else $error("control not zero at reset");

    property p_rom_addr;
        @(posedge clk) disable iff (sys_rst) rom_addr[5:0] == a[5:0];
    endproperty
    a_rom_addr: assert property (p_rom_addr) else $error("rom offset wrong");

    property p_rom_read;
        @(posedge clk) disable iff (sys_rst) core_req.rd && hit_win |=> core_rdata == $past(rom_data);
    endproperty
    a_rom_read: assert property (p_rom_read) else $error("window read wrong");

    property p_busy_len;
        @(posedge clk) disable iff (sys_rst) $fell(busy) |-> busy_run_q == 16'(PROG_WAIT);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

    property p_no_ena;
        @(posedge clk) disable iff (sys_rst)
            st_q == EE_IDLE && !ctl_q[CTL_ROW_BIT] && !ctl_q[CTL_ENA_BIT] |=> !busy;
    endproperty
    a_no_ena: assert property (p_no_ena) else $error("write without enable");

    property p_busy_end;
        @(posedge clk) disable iff (sys_rst) busy |-> busy_run_q < 16'(PROG_WAIT);
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy never ends");

    property p_byte_start;
        @(posedge clk) disable iff (sys_rst) st_q == EE_IDLE && !ctl_q[CTL_ROW_BIT] && ee_wr |=> busy;
    endproperty
    a_byte_start: assert property (p_byte_start) else $error("byte write not started");

    property p_off_block;
        @(posedge clk) disable iff (sys_rst) ctl_q[CTL_OFF_BIT] |-> !ee_wr;
    endproperty
    a_off_block: assert property (p_off_block) else $error("write while off");

    property p_busy_ctl;
        @(posedge clk) disable iff (sys_rst) busy && $past(busy) && cnt_q != 16'h0000 |-> $stable(ctl_q[CTL_ENA_BIT]);
    endproperty
    a_busy_ctl: assert property (p_busy_ctl) else $error("control changed while busy");

    property p_win_load;
        @(posedge clk) disable iff (sys_rst) core_req.wr && a == ROM_WINDOW_ADDR |=>
            rom_addr[ROM_AW-1:OFFSET_BITS] == 7'($past(core_req.wdata));
    endproperty
    a_win_load: assert property (p_win_load) else $error("window bits wrong");

    property p_rd_hold;
        @(posedge clk) disable iff (sys_rst) !core_req.rd |=> $stable(core_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

    property p_ctl_read;
        @(posedge clk) disable iff (sys_rst) core_req.rd && a == EE_CTRL_ADDR |=>
            core_rdata == {6'h00, $past(busy), 1'b0};
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("busy flag read wrong");

    property p_busy_read;
        @(posedge clk) disable iff (sys_rst) core_req.rd && hit_bank && !ram_sel && busy |=>
            core_rdata == 8'h00;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("read while busy");

    property p_nosel_read;
        @(posedge clk) disable iff (sys_rst) core_req.rd && hit_bank && !ram_sel && !ee_sel |=>
            core_rdata == 8'h00;
    endproperty
    a_nosel_read: assert property (p_nosel_read) else $error("unselected bank read");

    property p_row_clear;
        @(posedge clk) disable iff (sys_rst) $fell(busy) && !byte_mode_q |->
            !ctl_q[CTL_ROW_BIT] && !ctl_q[CTL_START_BIT];
    endproperty
    a_row_clear: assert property (p_row_clear) else $error("row bits not cleared");

    property p_start_row;
        @(posedge clk) disable iff (sys_rst) ctl_q[CTL_START_BIT] |->
            ctl_q[CTL_ROW_BIT] && ctl_q[CTL_ENA_BIT];
    endproperty
    a_start_row: assert property (p_start_row) else $error("start without row mode");

    c_byte:  cover property (@(posedge clk) disable iff (sys_rst) $rose(busy) && byte_mode_q == 1'b1 ##1 1'b1);
    c_deny:  cover property (@(posedge clk) disable iff (sys_rst) busy && core_req.rd && hit_bank);
    c_row:   cover property (@(posedge clk) disable iff (sys_rst) st_q == EE_ROW_LOAD ##1 busy);
    c_win:   cover property (@(posedge clk) disable iff (sys_rst) core_req.rd && hit_win);
    c_bank:  cover property (@(posedge clk) disable iff (sys_rst) core_req.rd && hit_bank && ram_sel);
endmodule // data_space_mapper

/* File: logic/data_space_pkg.sv */
// Package with the data-space map, register fields and timing of the mapper.
package data_space_pkg;
    // ------------------------------------------------------------------
    // Data-space addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] BANK_LO         = 8'h00;
    localparam logic [7:0] BANK_HI         = 8'h3f;
    localparam logic [7:0] ROMWIN_LO       = 8'h40;
    localparam logic [7:0] ROMWIN_HI       = 8'h7f;
    localparam logic [7:0] SRAM_LO         = 8'h80;
    localparam logic [7:0] SRAM_HI         = 8'hbf;
    localparam logic [7:0] ROM_WINDOW_ADDR = 8'hc9;
    localparam logic [7:0] BANK_SEL_ADDR   = 8'hcb;
    localparam logic [7:0] EE_CTRL_ADDR    = 8'hdf;
    localparam logic [7:0] LCD_LO          = 8'he0;
    localparam logic [7:0] LCD_HI          = 8'hf7;
    // ------------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------------
    localparam int OFFSET_BITS   = 6;
    localparam int WINDOW_BITS   = 7;
    localparam int ROM_AW        = 13;
    localparam int LCD_DEPTH     = 24;
    localparam int EE_DEPTH      = 64;
    localparam int ROW_BYTES     = 8;
    localparam int BANK_EE_BIT   = 0;
    localparam int BANK_RAM_BIT  = 3;
    localparam int CTL_ENA_BIT   = 0;
    localparam int CTL_BUSY_BIT  = 1;
    localparam int CTL_ROW_BIT   = 2;
    localparam int CTL_START_BIT = 3;
    localparam int CTL_OFF_BIT   = 6;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // ------------------------------------------------------------------
    // Programming time
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 25;
    localparam int PROG_TIME_US = 5;
    localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_s;

    typedef enum logic [1:0] {EE_IDLE, EE_ROW_LOAD, EE_PROG} ee_state_e;
endpackage

/* File: tb/rom_model.sv */
// Program ROM model that answers the mapper's window reads.
`timescale 1ns/1ps
module rom_model
    import data_space_pkg::*;
(
    // ROM read port
    input  wire logic [ROM_AW-1:0] rom_addr,
    output logic      [7:0]        rom_data
);
    // Every byte differs from its neighbours, so a wrong address bit shows.
    assign rom_data = rom_addr[7:0] ^ {3'h0, rom_addr[12:8]};
endmodule // rom_model

/* File: tb/tb_top.sv */
// Self-checking testbench of the data-space mapper with a reference model.
`timescale 1ns/1ps
module tb_top
    import data_space_pkg::*;
;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    core_req_s         core_req = '0;
    logic [7:0]        core_rdata;
    logic [7:0]        rom_data;
    logic [ROM_AW-1:0] rom_addr;
    logic              ee_busy;
    int                n_fail = 0;
    int                checks = 0;
    int                cyc = 0;
    logic [31:0]       seed = 32'hd169;
    logic [7:0]        win_m, bank_m, ctl_m, d, v;
    logic [7:0]        ram_m [0:255];
    logic [7:0]        pg_m [0:63];
    logic [7:0]        ee_m [0:63];
    logic [7:0]        al [0:7] = '{8'h80, 8'h9c, 8'hbf, 8'he0, 8'hea, 8'hf7, 8'h00, 8'h3f};
    logic [7:0]        rl [0:2] = '{8'h18, 8'h1a, 8'h1b};

    data_space_mapper #(.PROG_WAIT(12)) DUT (.clk(clk), .sys_rst(sys_rst), .core_req(core_req),
        .core_rdata(core_rdata), .rom_addr(rom_addr), .rom_data(rom_data), .ee_busy(ee_busy));
    rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a <= BANK_HI)
            return bank_m[BANK_RAM_BIT] ? pg_m[a[5:0]] :
                   (bank_m[BANK_EE_BIT] && !ctl_m[CTL_OFF_BIT]) ? ee_m[a[5:0]] : 8'h00;
        if (a <= ROMWIN_HI)
            return 8'({win_m[6:0], a[5:0]}) ^ {3'h0, win_m[6:2]};
        if ((a >= SRAM_LO && a <= SRAM_HI) || (a >= LCD_LO && a <= LCD_HI))
            return ram_m[a];
        return 8'h00;
    endfunction

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        core_req.rd = !w;
        core_req.wr = w;
        core_req.addr = a;
        core_req.wdata = dat;
        @(negedge clk);
        core_req.rd = 1'b0;
        core_req.wr = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        if (a == ROM_WINDOW_ADDR) win_m = dat;
        else if (a == BANK_SEL_ADDR) bank_m = dat;
        else if (a == EE_CTRL_ADDR) ctl_m = dat;
        else if (a <= BANK_HI && bank_m[BANK_RAM_BIT]) pg_m[a[5:0]] = dat;
        else if ((a >= SRAM_LO && a <= SRAM_HI) || (a >= LCD_LO && a <= LCD_HI)) ram_m[a] = dat;
        bus(1'b1, a, dat);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        if (a >= ROMWIN_LO && a <= ROMWIN_HI)
            chk("rom_addr", 16'(rom_addr), 16'({win_m[6:0], a[5:0]}));
        @(negedge clk);
        chk("core_rdata", 16'(core_rdata), 16'(e));
    endtask

    task automatic rd(input logic [7:0] a);
        rdx(a, exp_rd(a));
    endtask

    task automatic wait_idle();
        int i;
        i = 0;
        while (ee_busy !== 1'b0 && i < 50) begin
            @(negedge clk);
            i++;
        end
        chk("ee_busy", 16'(ee_busy), 16'h0000);
    endtask

    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        ctl_m = CTL_RESET;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        chk("ee_busy", 16'(ee_busy), 16'h0000);
        chk("core_rdata", 16'(core_rdata), 16'h0000);
        rd(EE_CTRL_ADDR);
        for (int i = 0; i < 6; i++) begin
            wr(ROM_WINDOW_ADDR, i == 0 ? 8'hff : rnd());
            rd(ROMWIN_LO);
            rd(ROMWIN_HI);
            rd(ROMWIN_LO | (rnd() & 8'h3f));
        end
        rd(ROM_WINDOW_ADDR);
        rd(BANK_SEL_ADDR);
        wr(BANK_SEL_ADDR, 8'h08);
        for (int i = 0; i < 8; i++) wr(al[i], rnd());
        for (int i = 0; i < 8; i++) rd(al[i]);
        wr(BANK_SEL_ADDR, 8'h00);
        wr(8'h00, rnd());
        rd(8'h00);
        wr(BANK_SEL_ADDR, 8'h08);
        rd(8'h00);
        wr(EE_CTRL_ADDR, 8'h01);
        wr(BANK_SEL_ADDR, 8'h01);
        d = rnd();
        wr(8'h05, d);
        ee_m[5] = d;
        @(negedge clk);
        chk("ee_busy", 16'(ee_busy), 16'h0001);
        bus(1'b1, EE_CTRL_ADDR, 8'h00);
        rdx(EE_CTRL_ADDR, 8'h02);
        rdx(8'h05, 8'h00);
        wait_idle();
        rd(8'h05);
        wr(8'h06, ~d);
        ee_m[6] = ~d;
        wait_idle();
        rd(8'h06);
        wr(EE_CTRL_ADDR, 8'h00);
        wr(8'h05, ~d);
        chk("ee_busy", 16'(ee_busy), 16'h0000);
        rd(8'h05);
        wr(EE_CTRL_ADDR, 8'h41);
        rd(8'h05);
        wr(EE_CTRL_ADDR, 8'h01);
        v = rnd();
        wr(8'h3f, v);
        ee_m[63] = v;
        wait_idle();
        rd(8'h3f);
        wr(EE_CTRL_ADDR, 8'h05);
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            wr(rl[i], v);
            ee_m[rl[i][5:0]] = v;
        end
        wr(EE_CTRL_ADDR, 8'h0d);
        @(negedge clk);
        chk("ee_busy", 16'(ee_busy), 16'h0001);
        wait_idle();
        for (int i = 0; i < 3; i++) rd(rl[i]);
        rd(8'h05);
        wr(EE_CTRL_ADDR, 8'h41);
        @(negedge clk);
        sys_rst = 1'b1;
        ctl_m = CTL_RESET;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk("ee_busy", 16'(ee_busy), 16'h0000);
        chk("core_rdata", 16'(core_rdata), 16'h0000);
        wr(BANK_SEL_ADDR, 8'h01);
        rd(8'h05);
        wr(8'h05, ~d);
        chk("ee_busy", 16'(ee_busy), 16'h0000);
        rd(8'h05);
        summarize();
    end
endmodule // tb_top
